// File: logic/led_drv_pkg.sv
package led_drv_pkg;
	localparam int unsigned WIDTH = 16;
	localparam logic [15:0] SHIFT_RST = 16'h0000;
	localparam logic [15:0] LATCH_RST = 16'h0000;
	localparam logic [15:0] OUT_OFF = 16'h0000;
	localparam int unsigned LAST_POS = 15;
	localparam int unsigned FIRST_POS = 0;
	typedef logic [15:0] word_t;
endpackage

// File: logic/edge_if.sv
interface edge_if;
	logic shift_lvl;
	logic latch_lvl;
	logic shift_rise;
	logic latch_rise;
	modport det (input shift_lvl, latch_lvl, output shift_rise, latch_rise);
	modport core (output shift_lvl, latch_lvl, input shift_rise, latch_rise);
endinterface

// File: logic/clock_edge_detect.sv
module clock_edge_detect (
	input  wire logic mclk_in,
	input  wire logic nrst_in,
	edge_if.det       ef
);
	typedef struct packed {
		logic shift_prev;
		logic latch_prev;
	} det_s;

	det_s st_q;
	det_s st_d;

	// Remember previous clock levels
	always_comb begin
		st_d = st_q;
		st_d.shift_prev = ef.shift_lvl;
		st_d.latch_prev = ef.latch_lvl;
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Low to high transitions only
	assign ef.shift_rise = ef.shift_lvl & ~st_q.shift_prev;
	assign ef.latch_rise = ef.latch_lvl & ~st_q.latch_prev;

	a_rise_shift : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ef.shift_rise |-> $rose(ef.shift_lvl) || !st_q.shift_prev)
		else $error("shift rise without low to high");
endmodule

// File: logic/led_shift_latch_driver16.sv
module led_shift_latch_driver16 (
	// Clock and reset
	input  wire logic                          mclk_in,
	input  wire logic                          nrst_in,
	// Host serial link
	input  wire logic                          serial_data_in,
	input  wire logic                          shift_clock_in,
	input  wire logic                          latch_clock_in,
	input  wire logic                          out_disable_in,
	// LED pins and cascade output
	output logic [led_drv_pkg::WIDTH-1:0]      led_outputs_out,
	output logic [led_drv_pkg::WIDTH-1:0]      led_outputs_oe_out,
	output logic                               serial_data_out
);
	import led_drv_pkg::*;

	typedef struct packed {
		word_t shift_reg;
		word_t latch_reg;
		word_t led_oe;
		logic  ser_out;
	} core_s;

	core_s st_q;
	core_s st_d;
	edge_if ef ();
	wire word_t shift_next;
	wire word_t latch_next;

	// One shift stage and one latch stage per bit
	for (genvar b = 0; b < WIDTH; b++) begin : g_bit
		if (b == FIRST_POS) begin : g_first
			// First stage takes the serial input
			assign shift_next[b] = serial_data_in;
		end else begin : g_rest
			// Later stages take their predecessor
			assign shift_next[b] = st_q.shift_reg[b-1];
		end
		// Latch stage sees its own shift stage
		assign latch_next[b] = st_q.shift_reg[b];

		a_bit_shift : assert property (@(posedge mclk_in)
			disable iff (!nrst_in)
			ef.shift_rise |=> st_q.shift_reg[b] == $past(shift_next[b]))
			else $error("bit stage did not shift");
		a_bit_latch : assert property (@(posedge mclk_in)
			disable iff (!nrst_in)
			ef.latch_rise |=> st_q.latch_reg[b] == $past(st_q.shift_reg[b]))
			else $error("bit latch did not copy");
		a_bit_hold : assert property (@(posedge mclk_in)
			disable iff (!nrst_in)
			!ef.latch_rise |=> $stable(st_q.latch_reg[b]))
			else $error("bit latch moved without edge");
		a_bit_drive : assert property (@(posedge mclk_in)
			disable iff (!nrst_in)
			led_outputs_out[b] == led_outputs_oe_out[b])
			else $error("bit pin value differs from enable");
		a_bit_off : assert property (@(posedge mclk_in)
			disable iff (!nrst_in)
			$past(out_disable_in) |-> !led_outputs_oe_out[b])
			else $error("bit driven while disabled");
	end

	assign ef.shift_lvl = shift_clock_in;
	assign ef.latch_lvl = latch_clock_in;

	clock_edge_detect u_edge (
		.mclk_in (mclk_in),
		.nrst_in (nrst_in),
		.ef      (ef.det)
	);

	always_comb begin
		st_d = st_q;
		// Shift stage per bit
		if (ef.shift_rise) begin
			st_d.shift_reg = shift_next;
		end
		// Latch takes pre-shift contents
		if (ef.latch_rise) begin
			st_d.latch_reg = latch_next;
		end
		// Pin value equals its enable, so a driven pin is high; gated by disable
		st_d.led_oe = out_disable_in ? OUT_OFF : st_d.latch_reg;
		st_d.ser_out = st_d.shift_reg[LAST_POS];
	end

	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q.shift_reg <= SHIFT_RST;
			st_q.latch_reg <= LATCH_RST;
			st_q.led_oe    <= OUT_OFF;
			st_q.ser_out   <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign led_outputs_out    = st_q.led_oe;
	assign led_outputs_oe_out = st_q.led_oe;
	assign serial_data_out    = st_q.ser_out;

	sequence s_shift_edge;
		ef.shift_rise;
	endsequence

	sequence s_latch_edge;
		ef.latch_rise && !ef.shift_rise;
	endsequence

	sequence s_tied_edge;
		ef.latch_rise && ef.shift_rise;
	endsequence

	sequence s_quiet_latch;
		!ef.latch_rise && $stable(out_disable_in);
	endsequence

	a_shift_in_data : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_shift_edge |=> st_q.shift_reg[FIRST_POS] == $past(serial_data_in))
		else $error("serial input not loaded");
	a_shift_moves_up : assert property (@(posedge mclk_in)
		disable iff (!nrst_in)
		s_shift_edge |=> st_q.shift_reg[WIDTH-1:1]
			== $past(st_q.shift_reg[WIDTH-2:0]))
		else $error("stages did not move");
	a_shift_holds : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		!ef.shift_rise |=> $stable(st_q.shift_reg))
		else $error("shift without edge");
	a_latch_copy : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		ef.latch_rise |=> st_q.latch_reg == $past(st_q.shift_reg))
		else $error("latch did not copy");
	a_tied_delay : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_tied_edge |=>
			st_q.latch_reg == {$past(st_q.shift_reg[WIDTH-1]),
				st_q.shift_reg[WIDTH-1:1]})
		else $error("tied clocks not one behind");
	a_led_follow : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(s_latch_edge and !out_disable_in) |=>
			led_outputs_oe_out == st_q.latch_reg)
		else $error("leds not following latch");
	a_led_steady : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_quiet_latch |=> $stable(led_outputs_oe_out))
		else $error("leds moved without latch edge");
	a_serial_step : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		s_shift_edge |=>
			serial_data_out == $past(st_q.shift_reg[LAST_POS-1]))
		else $error("serial out did not follow shift");
	a_disable_off : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		$past(out_disable_in) |-> led_outputs_oe_out == OUT_OFF)
		else $error("outputs driven while disabled");
	a_serial_last : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		serial_data_out == st_q.shift_reg[LAST_POS])
		else $error("serial out not last stage");
	a_disable_shift : assert property (@(posedge mclk_in) disable iff (!nrst_in)
		(out_disable_in and s_shift_edge) |=>
			st_q.shift_reg == {$past(st_q.shift_reg[WIDTH-2:0]),
				$past(serial_data_in)})
		else $error("disable blocked shifting");
	a_reset_clear : assert property (@(posedge mclk_in)
		!nrst_in |-> st_q.latch_reg == LATCH_RST && !serial_data_out)
		else $error("reset did not clear");
	a_reset_off : assert property (@(posedge mclk_in)
		!nrst_in |-> led_outputs_oe_out == OUT_OFF
			&& st_q.shift_reg == SHIFT_RST)
		else $error("reset left outputs or stages set");
endmodule

// File: tb/host_model.sv
module host_model (
	input  wire logic mclk_in,
	output logic      sdi_out,
	output logic      sck_out,
	output logic      lck_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {sdi_out, sck_out, lck_out} = 3'h0;
	// Shared clocks for cascading; data inverts on the edge the clocks fall
	task automatic pulse(input logic d, s, l);
		@(negedge mclk_in);
		sdi_out = d;
		{sck_out, lck_out} = {s, l};
		@(negedge mclk_in);
		{sck_out, lck_out} = 2'h0;
		sdi_out = ~d;
	endtask
endmodule

// File: tb/led_shift_latch_driver16_tb.sv
module led_shift_latch_driver16_tb;
	import led_drv_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk_in = 0, nrst_in = 0, dis = 0, chk = 0;
	logic        sd, sc, lc, so;
	word_t       oe, led, sr = '0, lt = '0;
	logic [16:0] exp_q[$];
	int          failures = 0, checks = 0;
	logic [31:0] rs = 32'h9347328C;
	always #10 mclk_in = ~mclk_in;
	host_model host (.mclk_in(mclk_in), .sdi_out(sd), .sck_out(sc),
		.lck_out(lc));
	led_shift_latch_driver16 uut (.mclk_in(mclk_in), .nrst_in(nrst_in),
		.serial_data_in(sd), .shift_clock_in(sc), .latch_clock_in(lc),
		.out_disable_in(dis), .led_outputs_out(led),
		.led_outputs_oe_out(oe), .serial_data_out(so));
	function automatic logic rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs[0];
	endfunction
	task automatic note(input logic [16:0] e);
		exp_q.push_back(e);
		chk = 1;
		@(negedge mclk_in);
		chk = 0;
	endtask
	// Latch takes pre-shift contents
	task automatic step(input logic d, s, l);
		host.pulse(d, s, l);
		if (l) lt = sr;
		if (s) sr = {sr[14:0], d};
		repeat (2) @(negedge mclk_in);
		note({dis ? 16'h0000 : lt, sr[15]});
	endtask
	task automatic wrap_up();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge mclk_in) if (chk) begin
		logic [16:0] e;
		e = exp_q.pop_front();
		checks++;
		if ({oe, so} !== e || led !== oe) begin
			failures++;
			$display("[ERR] oe,sdo exp %h got %h led %h", e, {oe, so}, led);
		end
	end
	initial begin
		repeat (10) @(negedge mclk_in);
		nrst_in = 1;
		for (int i = 0; i < 16; i++) step(rnd(), 1, 0);
		step(rnd(), 0, 1);
		dis = 1;
		step(rnd(), 1, 0);
		step(rnd(), 1, 1);
		dis = 0;
		step(rnd(), 1, 1);
		for (int i = 0; i < 16; i++) step(0, 1, i == 15);
		nrst_in = 0;
		sr = '0;
		lt = '0;
		note(17'h0);
		nrst_in = 1;
		step(1, 1, 1);
		wrap_up();
	end
	initial begin
		#20000;
		failures++;
		wrap_up();
	end
endmodule
